// >>> tb/lext_props.sv
`timescale 1ns/1ps
`default_nettype none
module lext_props #(
    parameter int unsigned RAW_W = 16
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    // Configuration
    input wire logic i_trig_enable,
    input wire logic [RAW_W-1:0] i_readout_raw,
    input wire logic [RAW_W-1:0] i_overlap_max_raw,
    input wire logic i_ovr_clear,
    // Status
    input wire logic o_expo_active,
    input wire logic o_trig_wait,
    input wire logic o_readout_active,
    input wire logic o_overtrigger,
    input wire logic [RAW_W-1:0] o_readout_time_us
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);
    logic [7:0] gap_q, gap_d;
    always_comb begin
        gap_d = (gap_q == 8'hff) ? gap_q : gap_q + 8'h01;
        if (o_expo_active)
            gap_d = 8'h00;
    end
    always_ff @(posedge i_sys_clk) gap_q <= i_sys_rst ? 8'hff : gap_d;
    start_delay_a:
    assert property ($fell(o_trig_wait) && i_trig_enable |->
        ##[36:40] $rose(o_expo_active)) else $error("start delay wrong");
    wait_idle_a:
    assert property (o_trig_wait |-> i_trig_enable && !o_expo_active)
        else $error("waiting while busy");
    overhead_gap_a:
    assert property (o_trig_wait |-> gap_q >= 8'd133)
        else $error("waiting inside exposure overhead");
    readout_load_a:
    assert property ($fell(o_expo_active) && i_readout_raw != 16'h0000
        |-> ##[0:1] o_readout_active) else $error("readout not started");
    no_overlap_a:
    assert property (o_trig_wait && i_overlap_max_raw == 16'h0000
        |-> !o_readout_active) else $error("wait during readout");
    ovr_cause_a:
    assert property ($rose(o_overtrigger) |-> $past(i_trig_enable)
        && !$past(o_trig_wait)) else $error("overtrigger without cause");
    ovr_sticky_a:
    assert property (o_overtrigger && !i_ovr_clear |=> o_overtrigger)
        else $error("overtrigger flag lost");
    ovr_clear_a:
    assert property (i_ovr_clear && !i_trig_enable |=> !o_overtrigger)
        else $error("overtrigger flag not cleared");
    readout_us_a:
    assert property (!$past(i_sys_rst) |->
        o_readout_time_us == $past(i_readout_raw) / 16'd10)
        else $error("readout time value wrong");
    cover property ($rose(o_expo_active));
    cover property (o_expo_active && o_readout_active);
    cover property ($rose(o_overtrigger));
endmodule : lext_props
bind lext_line_trigger lext_props #(.RAW_W(RAW_W)) u_props (.*);
`default_nettype wire

// >>> tb/lext_trig_src.sv
`timescale 1ns/1ps
`default_nettype none
module lext_trig_src (
    // Clock and readiness seen from the device
    input wire logic i_clk,
    input wire logic i_wait,
    // Camera control lines
    output logic [3:0] o_lines
);
    logic idle_lvl = 1'b0;
    logic act = 1'b0;
    logic [2:0] noise = 3'h0;
    // Unselected lines keep toggling so a wrong source pick shows up
    always @(posedge i_clk) noise <= noise + 3'h1;
    assign o_lines = {noise, idle_lvl ^ act};
    task automatic pulse(input bit obey, input int hi);
        int n;
        n = 0;
        while (obey && i_wait !== 1'b1 && n < 5000) begin
            @(posedge i_clk);
            n++;
        end
        act <= 1'b1;
        repeat (hi) @(posedge i_clk);
        act <= 1'b0;
        @(posedge i_clk);
    endtask : pulse
endmodule : lext_trig_src
`default_nettype wire

// >>> tb/test_line_exposure_trigger_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_line_exposure_trigger_control;
    logic i_sys_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic i_clk_en = 1'b1;
    wire logic [3:0] i_ctrl_inputs;
    logic i_trig_enable = 1'b1;
    logic [1:0] i_trig_src = 2'h0;
    logic i_trig_rising = 1'b1;
    logic i_expo_width_mode = 1'b0;
    logic i_ovr_clear = 1'b0;
    logic [15:0] i_debounce_raw = 16'h0000;
    logic [15:0] i_expo_time_raw = 16'h0014;
    logic [15:0] i_readout_raw = 16'h0028;
    logic [15:0] i_overlap_max_raw = 16'h0000;
    logic o_expo_active, o_trig_wait, o_readout_active, o_overtrigger;
    logic [15:0] o_readout_time_us;
    logic prev_q = 1'b0;
    logic ovl;
    int errors = 0;
    int cmp_count = 0;
    int rises = 0;
    int a, b, r;
    lext_line_trigger u_dut (.*);
    lext_trig_src u_src (.i_clk(i_sys_clk), .i_wait(o_trig_wait),
        .o_lines(i_ctrl_inputs));
    initial forever #20 i_sys_clk = ~i_sys_clk;
    always @(posedge i_sys_clk) begin
        prev_q <= o_expo_active;
        if (o_expo_active && !prev_q) rises <= rises + 1;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic near(input int v, input int lo, input int hi);
        check(16'(v >= lo && v <= hi), 16'h0001);
    endtask : near
    task automatic cyc(input int n);
        repeat (n) @(posedge i_sys_clk);
    endtask : cyc
    task automatic wait_expo(input logic v, output int n);
        n = 0;
        while (o_expo_active !== v && n < 3000) begin
            @(posedge i_sys_clk);
            n++;
        end
    endtask : wait_expo
    task automatic ready();
        int n;
        n = 0;
        while (o_trig_wait !== 1'b1 && n < 2000) begin
            @(posedge i_sys_clk);
            n++;
        end
        near(n, 0, 1999);
    endtask : ready
    // Latency a to exposure start, b to exposure end, from the line edge
    task automatic line(input int hi);
        ready();
        fork
            u_src.pulse(1'b1, hi);
            begin
                wait_expo(1'b1, a);
                ovl = o_readout_active;
                wait_expo(1'b0, b);
                b = a + b;
            end
        join
    endtask : line
    task automatic tally_and_finish();
        $display("errors=%0d compares=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        #1_000_000;
        errors++;
        tally_and_finish();
    end
    initial begin
        cyc(6);
        i_sys_rst <= 1'b0;
        cyc(1);
        check(16'(o_expo_active), 16'h0000);
        line(10);
        near(a, 39, 43);
        near(b, 80, 86);
        i_debounce_raw <= 16'h0032;
        line(200);
        near(a, 160, 172);
        near(b, 202, 214);
        $display("test delays done");
        i_debounce_raw <= 16'h0000;
        ready();
        r = rises;
        u_src.pulse(1'b0, 10);
        u_src.pulse(1'b0, 10);
        check(16'(o_overtrigger), 16'h0001);
        cyc(300);
        check(16'(rises - r), 16'h0001);
        i_ovr_clear <= 1'b1;
        cyc(2);
        i_ovr_clear <= 1'b0;
        i_trig_enable <= 1'b0;
        cyc(1);
        check(16'(o_overtrigger), 16'h0000);
        u_src.pulse(1'b0, 10);
        cyc(60);
        check(16'(o_overtrigger), 16'h0000);
        check(16'(rises - r), 16'h0001);
        i_ovr_clear <= 1'b1;
        cyc(1);
        i_ovr_clear <= 1'b0;
        i_trig_enable <= 1'b1;
        i_clk_en <= 1'b0;
        u_src.pulse(1'b0, 10);
        cyc(60);
        i_clk_en <= 1'b1;
        cyc(60);
        check(16'(rises - r), 16'h0001);
        check(16'(o_overtrigger), 16'h0000);
        $display("test overtrigger done");
        i_readout_raw <= 16'h00c8;
        i_overlap_max_raw <= 16'h012c;
        line(10);
        line(10);
        check(16'(ovl), 16'h0001);
        i_overlap_max_raw <= 16'h0000;
        line(10);
        check(16'(ovl), 16'h0000);
        check(o_readout_time_us, 16'h0014);
        $display("test overlap done");
        i_readout_raw <= 16'h0004;
        i_expo_width_mode <= 1'b1;
        i_overlap_max_raw <= 16'h012c;
        cyc(600);
        line(100);
        near(b, 130, 136);
        i_trig_enable <= 1'b0;
        u_src.idle_lvl <= 1'b1;
        cyc(20);
        i_trig_rising <= 1'b0;
        cyc(20);
        i_trig_enable <= 1'b1;
        line(100);
        near(a, 39, 43);
        near(b, 130, 136);
        i_readout_raw <= 16'h00c8;
        line(100);
        ready();
        u_src.pulse(1'b1, 100);
        cyc(60);
        check(16'(o_expo_active), 16'h0001);
        fork
            u_src.pulse(1'b0, 400);
            begin
                cyc(390);
                check(16'(o_expo_active), 16'h0001);
            end
        join
        cyc(40);
        check(16'(o_expo_active), 16'h0000);
        check(16'(o_overtrigger), 16'h0001);
        $display("test width done");
        tally_and_finish();
    end
endmodule : test_line_exposure_trigger_control
`default_nettype wire

// >>> verilog/lext_debounce.sv
`timescale 1ns/1ps
`default_nettype none
module lext_debounce
    import lext_pkg::*;
#(
    parameter int unsigned RAW_W = 16
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic i_clk_en,
    // Time base
    input wire logic i_tick,
    // Raw level and filter length in time base ticks
    input wire logic i_level,
    input wire logic [RAW_W-1:0] i_debounce_raw,
    // Filtered level
    output logic o_level
);
    logic lvl_q;
    logic lvl_d;
    logic [RAW_W-1:0] cnt_q;
    logic [RAW_W-1:0] cnt_d;

    // A change is taken only once it has stood for the whole debounce time,
    // so every edge leaves here late by that time, to within one time base tick.
    always_comb begin
        lvl_d = lvl_q;
        cnt_d = cnt_q;
        if (i_level == lvl_q) begin
            cnt_d = '0;
        end else if (cnt_q >= i_debounce_raw) begin
            lvl_d = i_level;
            cnt_d = '0;
        end else if (i_tick) begin
            cnt_d = cnt_q + 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            lvl_q <= 1'b0;
            cnt_q <= '0;
        end else if (i_clk_en) begin
            lvl_q <= lvl_d;
            cnt_q <= cnt_d;
        end
    end

    assign o_level = lvl_q;
endmodule : lext_debounce
`default_nettype wire

// >>> verilog/lext_line_trigger.sv
`timescale 1ns/1ps
`default_nettype none
// Operation
// RULE1: Exposure starts 1.5 us after trigger edge
// RULE2: Exposure ends 1.2 us after due end
// RULE3: Debounce time adds to both delays
// RULE4: Overlap follows line period versus exposure+readout
// RULE5: Non-overlapped lines complete before next exposure
// RULE6: Overlapped exposure may run during readout
// RULE7: Trigger while not waiting is overtrigger, ignored
// RULE8: Start during exposure or overhead is overtrigger
// RULE9: Fixed exposure overhead follows every exposure
// RULE10: Width-mode end before prior readout is illegal
// RULE11: Illegal early end extends to next end
// RULE12: Readout time readable in microseconds
// RULE13: Source triggers only while device is waiting
// RULE14: Raw settings count a 100 ns base
// RULE15: Exposure-active high exactly during exposure
// RULE16: Trigger-wait uses maximum exposure overlap time
// RULE17: Overtrigger sets sticky clearable status flag
// RULE18: Selectable edge polarity; opposite edge ends width
module lext_line_trigger
    import lext_pkg::*;
#(
    parameter int unsigned RAW_W = 16,
    parameter int unsigned N_INPUTS = 4
) (
    // Clock, reset, clock enable
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic i_clk_en,
    // Camera control inputs, index 0 is camera_control_input_one
    input wire logic [N_INPUTS-1:0] i_ctrl_inputs,
    // Trigger configuration
    input wire logic i_trig_enable,
    input wire logic [1:0] i_trig_src,
    input wire logic i_trig_rising,
    input wire logic [RAW_W-1:0] i_debounce_raw,
    // Exposure and readout configuration, time base counts
    input wire logic i_expo_width_mode,
    input wire logic [RAW_W-1:0] i_expo_time_raw,
    input wire logic [RAW_W-1:0] i_readout_raw,
    input wire logic [RAW_W-1:0] i_overlap_max_raw,
    // Status control
    input wire logic i_ovr_clear,
    // Monitoring and status
    output logic o_expo_active,
    output logic o_trig_wait,
    output logic o_readout_active,
    output logic o_overtrigger,
    output logic [RAW_W-1:0] o_readout_time_us
);
    lext_state_t state_q;
    lext_state_t state_d;
    logic [ACC_W-1:0] acc_q;
    logic [ACC_W-1:0] acc_d;
    logic [CNT_W-1:0] dly_q;
    logic [CNT_W-1:0] dly_d;
    logic [RAW_W-1:0] ecnt_q;
    logic [RAW_W-1:0] ecnt_d;
    logic [RAW_W-1:0] ro_q;
    logic [RAW_W-1:0] ro_d;
    logic [RAW_W-1:0] ro_us_q;
    logic [RAW_W-1:0] ro_us_d;
    logic ovr_q;
    logic ovr_d;
    logic expo_q;
    logic expo_d;
    logic ro_busy_q;
    logic ro_busy_d;
    logic pulse_q;
    logic tick;
    logic [ACC_W-1:0] acc_sum;
    logic src_level;
    logic active_level;
    logic external_line_start_pulse;
    logic start_edge;
    logic end_edge;
    logic armed;
    logic due_end;

    // Internal 100 ns time base from the 40 ns clock by fractional stepping
    assign acc_sum = acc_q + ACC_STEP;
    assign tick = (acc_sum >= ACC_WRAP); // RULE14

    always_comb begin
        acc_d = tick ? (acc_sum - ACC_WRAP) : acc_sum;
    end

    // Source select and polarity; afterwards high always means active
    assign src_level = (32'(i_trig_src) < N_INPUTS) ?
        i_ctrl_inputs[i_trig_src] : 1'b0;
    assign active_level = i_trig_rising ? src_level : ~src_level; // RULE18

    lext_debounce #(
        .RAW_W(RAW_W)
    ) u_debounce (
        .i_sys_clk(i_sys_clk),
        .i_sys_rst(i_sys_rst),
        .i_clk_en(i_clk_en),
        .i_tick(tick),
        .i_level(active_level),
        .i_debounce_raw(i_debounce_raw),
        .o_level(external_line_start_pulse)
    ); // RULE3

    assign start_edge = external_line_start_pulse & ~pulse_q; // RULE18
    assign end_edge = ~external_line_start_pulse & pulse_q; // RULE18

    // Ready when idle and the remaining readout of the previous line is no
    // longer than the overlap allowance, so that an exposure at least that
    // long cannot end before the previous readout has finished.
    assign armed = i_trig_enable && (state_q == LEXT_IDLE) &&
        (ro_q <= i_overlap_max_raw); // RULE16 RULE7

    // Due end of exposure: opposite edge in width mode, else timed counts from the accepted edge
    assign due_end = i_expo_width_mode ? end_edge :
        (ecnt_q >= i_expo_time_raw); // RULE2

    always_comb begin
        state_d = state_q;
        dly_d = dly_q;
        ecnt_d = ecnt_q;
        ro_d = ro_q;
        ovr_d = ovr_q;
        if (tick && (ro_q != '0)) begin
            ro_d = ro_q - 1'b1;
        end
        if (tick && (ecnt_q != '1)) begin
            ecnt_d = ecnt_q + 1'b1;
        end
        case (state_q)
            LEXT_IDLE: begin
                if (start_edge && armed) begin
                    state_d = LEXT_START_DLY; // RULE1
                    dly_d = START_DLY_LOAD; // RULE1
                    ecnt_d = '0;
                end
            end
            LEXT_START_DLY: begin
                if (dly_q == CNT_ZERO) begin
                    state_d = LEXT_EXPOSE; // RULE6
                end else begin
                    dly_d = dly_q - 1'b1;
                end
            end
            LEXT_EXPOSE: begin
                // In width mode an end that would overlap two readouts is dropped and the exposure
                // runs on to the next end after readout; a timed end is held until readout is done.
                if (due_end && (ro_q == '0)) begin // RULE10 RULE11
                    state_d = LEXT_END_DLY; // RULE2
                    dly_d = END_DLY_LOAD; // RULE2
                end
            end
            LEXT_END_DLY: begin
                if (dly_q == CNT_ZERO) begin
                    state_d = LEXT_OVERHEAD; // RULE9
                    dly_d = OVERHEAD_LOAD; // RULE9
                    ro_d = i_readout_raw; // RULE4 RULE5
                end else begin
                    dly_d = dly_q - 1'b1;
                end
            end
            LEXT_OVERHEAD: begin
                if (dly_q == CNT_ZERO) begin
                    state_d = LEXT_IDLE; // RULE9
                end else begin
                    dly_d = dly_q - 1'b1;
                end
            end
            default: begin
                state_d = LEXT_IDLE;
            end
        endcase
        // Set wins over a clear in the same cycle
        if (i_ovr_clear) begin
            ovr_d = 1'b0; // RULE17
        end
        if (i_trig_enable && start_edge && !armed) begin
            ovr_d = 1'b1; // RULE7 RULE8 RULE17
        end
    end

    // Registered status outputs
    always_comb begin
        expo_d = (state_d == LEXT_EXPOSE) || (state_d == LEXT_END_DLY);
        ro_busy_d = (ro_d != '0);
        ro_us_d = i_readout_raw / RAW_W'(TB_PER_US); // RULE12
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            state_q <= LEXT_IDLE;
            acc_q <= ACC_ZERO;
            dly_q <= CNT_ZERO;
            ecnt_q <= '0;
            ro_q <= '0;
            ro_us_q <= '0;
            ovr_q <= 1'b0;
            expo_q <= 1'b0;
            ro_busy_q <= 1'b0;
            pulse_q <= 1'b0;
        end else if (i_clk_en) begin
            state_q <= state_d;
            acc_q <= acc_d;
            dly_q <= dly_d;
            ecnt_q <= ecnt_d;
            ro_q <= ro_d;
            ro_us_q <= ro_us_d;
            ovr_q <= ovr_d;
            expo_q <= expo_d;
            ro_busy_q <= ro_busy_d;
            pulse_q <= external_line_start_pulse;
        end
    end

    assign o_expo_active = expo_q; // RULE15
    assign o_trig_wait = armed; // RULE16
    assign o_readout_active = ro_busy_q;
    assign o_overtrigger = ovr_q; // RULE17
    assign o_readout_time_us = ro_us_q; // RULE12
endmodule : lext_line_trigger
`default_nettype wire

// >>> verilog/lext_pkg.sv
package lext_pkg;
    // Clock and internal time base
    localparam int unsigned CLK_PERIOD_NS = 40;
    localparam int unsigned TIME_BASE_NS = 100;
    localparam int unsigned TB_PER_US = 1000 / TIME_BASE_NS;

    // Fixed exposure delays and exposure overhead, in nanoseconds
    localparam int unsigned START_DELAY_NS = 1500;
    localparam int unsigned END_DELAY_NS = 1200;
    localparam int unsigned EXPOSURE_OVERHEAD_DURATION_NS = 5400;

    // Same figures in clock cycles
    localparam int unsigned START_DELAY_CYC =
        (START_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned END_DELAY_CYC =
        (END_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned OVERHEAD_CYC =
        (EXPOSURE_OVERHEAD_DURATION_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Counter widths
    localparam int unsigned CNT_W = 8;
    localparam int unsigned ACC_W = 8;

    // Delay counter loads: a count of N cycles loads N-1
    localparam logic [CNT_W-1:0] START_DLY_LOAD = CNT_W'(START_DELAY_CYC - 1);
    localparam logic [CNT_W-1:0] END_DLY_LOAD = CNT_W'(END_DELAY_CYC - 1);
    localparam logic [CNT_W-1:0] OVERHEAD_LOAD = CNT_W'(OVERHEAD_CYC - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;

    // Time base accumulator steps
    localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(CLK_PERIOD_NS);
    localparam logic [ACC_W-1:0] ACC_WRAP = ACC_W'(TIME_BASE_NS);
    localparam logic [ACC_W-1:0] ACC_ZERO = 8'h00;

    // Trigger source codes
    localparam logic [1:0] SRC_CAMERA_CONTROL_INPUT_ONE = 2'h0;

    typedef enum logic [2:0] {
        LEXT_IDLE,
        LEXT_START_DLY,
        LEXT_EXPOSE,
        LEXT_END_DLY,
        LEXT_OVERHEAD
    } lext_state_t;
endpackage : lext_pkg
